// ### hdl/dual_timer.sv
// dual timer/counter with external interrupt detect flags
// Function
// - timer 1 overflow sets its flag; vectoring clears it; software writes it.
// - timer 0 overflow sets its flag; vectoring clears it; software writes it.
// - each timer counts only while its software run bit is set; in mode 11 the timer 0 high half uses the timer 1 run bit.
// - ext int 1 flag sets on edge or level; edge clears on vectoring, level tracks.
// - ext int 0 flag behaves the same as ext int 1.
// - per-input type bit selects falling edge or low level triggering.
// - gate set: count only while pin high and run bit set.
// - gate clear: count whenever run bit set.
// - select clear: increment on the internal machine-cycle tick.
// - select set: increment on each falling edge of the count pin.
// - mode 00: 8-bit counter with 5-bit prescaler.
// - mode 01: full 16-bit counter.
// - mode 10: 8-bit counter auto-reloading from high byte.
// - mode 11 on timer 0: split halves; mode 11 on timer 1: timer 1 stops.
`timescale 1ns/1ns
module dual_timer #(
	parameter int CLKS_PER_CYCLE = 4
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       count_pin0,
	input  wire logic       count_pin1,
	input  wire logic       ext_pin_a,
	input  wire logic       ext_pin_b,
	output logic            t0_overflow_flag,
	output logic            t1_overflow_flag,
	output logic            ext_ext_pin_a_detect,
	output logic            ext_ext_pin_b_detect
);
	initial begin
		if (CLKS_PER_CYCLE < 1 || CLKS_PER_CYCLE > 255)
			$error("CLKS_PER_CYCLE out of range");
	end

	////////////////////////////////////////////////////////////////////////
	logic [7:0] div_reg;
	logic       mc_tick;
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] tmode_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [3:0] ack;

	// machine-cycle enable from the device clock
	assign mc_tick = (div_reg == 8'(CLKS_PER_CYCLE - 1));
	always_ff @(posedge clk) begin
		if (reset)
			div_reg <= 8'h00;
		else
			div_reg <= mc_tick ? 8'h00 : div_reg + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// pins
	logic p0_lvl, p0_fall_raw, p1_lvl, p1_fall_raw;
	logic xa_lvl, xa_fall_raw, xb_lvl, xb_fall_raw;
	pin_sampler u_c0 (.clk(clk), .reset(reset), .pin(count_pin0), .level(p0_lvl), .fall(p0_fall_raw));
	pin_sampler u_c1 (.clk(clk), .reset(reset), .pin(count_pin1), .level(p1_lvl), .fall(p1_fall_raw));
	pin_sampler u_xa (.clk(clk), .reset(reset), .pin(ext_pin_a), .level(xa_lvl), .fall(xa_fall_raw));
	pin_sampler u_xb (.clk(clk), .reset(reset), .pin(ext_pin_b), .level(xb_lvl), .fall(xb_fall_raw));

	// latch edges between machine cycles so narrow pulses are not lost
	logic [3:0] edge_reg;
	logic [3:0] edge_now;
	assign edge_now = edge_reg | {xb_fall_raw, xa_fall_raw, p1_fall_raw, p0_fall_raw};
	always_ff @(posedge clk) begin
		if (reset || mc_tick)
			edge_reg <= 4'h0;
		else
			edge_reg <= edge_now;
	end
	logic p0_fall, p1_fall, xa_fall, xb_fall;
	assign p0_fall = mc_tick & edge_now[0];
	assign p1_fall = mc_tick & edge_now[1];
	assign xa_fall = mc_tick & edge_now[2];
	assign xb_fall = mc_tick & edge_now[3];

	////////////////////////////////////////////////////////////////////////
	// count enables
	function automatic logic count_en(input logic [3:0] cfg, input logic run, input logic pin_hi,
		input logic tick, input logic fall);
		logic allowed;
		allowed = run && (!cfg[tmr_pkg::BIT_GATE] || pin_hi);
		count_en = allowed && (cfg[tmr_pkg::BIT_CNT_SEL] ? fall : tick);
	endfunction

	logic [3:0] cfg0, cfg1;
	logic [1:0] mode0, mode1;
	logic       t0_run, t1_run;
	logic       tick0, tick1, hi_tick0;
	assign cfg0   = tmode_reg[3:0];
	assign cfg1   = tmode_reg[7:4];
	assign mode0  = cfg0[tmr_pkg::BIT_MODE_HI:tmr_pkg::BIT_MODE_LO];
	assign mode1  = cfg1[tmr_pkg::BIT_MODE_HI:tmr_pkg::BIT_MODE_LO];
	assign t0_run = ctrl_reg[tmr_pkg::BIT_T0_RUN];
	assign t1_run = ctrl_reg[tmr_pkg::BIT_T1_RUN];
	assign tick0  = count_en(cfg0, t0_run, xa_lvl, mc_tick, p0_fall);
	// timer 1 halts in mode 3; timer 0 in mode 3 lends its high half t1_run
	assign tick1  = (mode1 != tmr_pkg::MODE_SPLIT) && count_en(cfg1, t1_run, xb_lvl, mc_tick, p1_fall);
	assign hi_tick0 = t1_run && mc_tick;

	////////////////////////////////////////////////////////////////////////
	// timers
	logic [7:0] t0_lo, t0_hi, t1_lo, t1_hi;
	logic       t0_ovf, t0_hi_ovf, t1_ovf;
	logic       wr_ctrl, wr_tmode, wr_ack;
	assign wr_ctrl  = wr && addr == tmr_pkg::ADDR_TCTRL;
	assign wr_tmode = wr && addr == tmr_pkg::ADDR_TMODE;
	assign wr_ack   = wr && addr == tmr_pkg::ADDR_ACK;
	assign ack      = wr_ack ? wdata[3:0] : 4'h0;

	timer_core u_t0 (
		.clk(clk), .reset(reset), .mode(mode0), .tick(tick0), .hi_tick(hi_tick0),
		.wr_lo(wr && addr == tmr_pkg::ADDR_T0LO), .wr_hi(wr && addr == tmr_pkg::ADDR_T0HI),
		.wdata(wdata), .lo_byte(t0_lo), .hi_byte(t0_hi), .ovf(t0_ovf), .hi_ovf(t0_hi_ovf)
	);
	timer_core u_t1 (
		.clk(clk), .reset(reset), .mode(mode1), .tick(tick1), .hi_tick(1'b0),
		.wr_lo(wr && addr == tmr_pkg::ADDR_T1LO), .wr_hi(wr && addr == tmr_pkg::ADDR_T1HI),
		.wdata(wdata), .lo_byte(t1_lo), .hi_byte(t1_hi), .ovf(t1_ovf), .hi_ovf()
	);

	////////////////////////////////////////////////////////////////////////
	// flags: hardware set wins over any clear in the same cycle
	logic set_t0, set_t1;
	logic x0_set, x1_set;
	assign set_t0 = t0_ovf;
	// in split mode the timer 0 high half also sets the timer 1 flag, beside timer 1 overflow
	assign set_t1 = t1_ovf | (mode0 == tmr_pkg::MODE_SPLIT && t0_hi_ovf);
	// level mode follows the sampled pin, edge mode latches falls
	assign x0_set = ctrl_reg[tmr_pkg::BIT_X0_TYPE] ? xa_fall : 1'b0;
	assign x1_set = ctrl_reg[tmr_pkg::BIT_X1_TYPE] ? xb_fall : 1'b0;

	function automatic logic flag_next(input logic cur, input logic set, input logic wr_en,
		input logic wbit, input logic clr);
		logic v;
		v = cur;
		if (clr)
			v = 1'b0;
		if (wr_en)
			v = wbit;
		flag_next = v | set;
	endfunction

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
			ctrl_next = wdata;
		ctrl_next[tmr_pkg::BIT_T0_FLAG] = flag_next(ctrl_reg[tmr_pkg::BIT_T0_FLAG], set_t0, wr_ctrl,
			wdata[tmr_pkg::BIT_T0_FLAG], ack[tmr_pkg::ACK_T0]);
		ctrl_next[tmr_pkg::BIT_T1_FLAG] = flag_next(ctrl_reg[tmr_pkg::BIT_T1_FLAG], set_t1, wr_ctrl,
			wdata[tmr_pkg::BIT_T1_FLAG], ack[tmr_pkg::ACK_T1]);
		if (ctrl_next[tmr_pkg::BIT_X0_TYPE])
			ctrl_next[tmr_pkg::BIT_X0_DET] = flag_next(ctrl_reg[tmr_pkg::BIT_X0_DET], x0_set, wr_ctrl,
				wdata[tmr_pkg::BIT_X0_DET], ack[tmr_pkg::ACK_X0]);
		else
			ctrl_next[tmr_pkg::BIT_X0_DET] = ~xa_lvl;
		if (ctrl_next[tmr_pkg::BIT_X1_TYPE])
			ctrl_next[tmr_pkg::BIT_X1_DET] = flag_next(ctrl_reg[tmr_pkg::BIT_X1_DET], x1_set, wr_ctrl,
				wdata[tmr_pkg::BIT_X1_DET], ack[tmr_pkg::ACK_X1]);
		else
			ctrl_next[tmr_pkg::BIT_X1_DET] = ~xb_lvl;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg  <= tmr_pkg::RESET_BYTE;
			tmode_reg <= tmr_pkg::RESET_BYTE;
		end else begin
			ctrl_reg <= ctrl_next;
			if (wr_tmode)
				tmode_reg <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: data in the cycle after the strobe, zero elsewhere
	always_comb begin
		rdata_next = 8'h00;
		if (rd && addr == tmr_pkg::ADDR_TCTRL)
			rdata_next = ctrl_reg;
		else if (rd && addr == tmr_pkg::ADDR_TMODE)
			rdata_next = tmode_reg;
		else if (rd && addr == tmr_pkg::ADDR_T0LO)
			rdata_next = t0_lo;
		else if (rd && addr == tmr_pkg::ADDR_T0HI)
			rdata_next = t0_hi;
		else if (rd && addr == tmr_pkg::ADDR_T1LO)
			rdata_next = t1_lo;
		else if (rd && addr == tmr_pkg::ADDR_T1HI)
			rdata_next = t1_hi;
	end

	always_ff @(posedge clk) begin
		if (reset)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	assign rdata            = rdata_reg;
	assign t0_overflow_flag = ctrl_reg[tmr_pkg::BIT_T0_FLAG];
	assign t1_overflow_flag = ctrl_reg[tmr_pkg::BIT_T1_FLAG];
	assign ext_ext_pin_a_detect  = ctrl_reg[tmr_pkg::BIT_X0_DET];
	assign ext_ext_pin_b_detect  = ctrl_reg[tmr_pkg::BIT_X1_DET];

	////////////////////////////////////////////////////////////////////////
	sequence t0_overflow_s;
		t0_ovf;
	endsequence
	sequence t0_flag_up_s;
		##1 t0_overflow_flag;
	endsequence

	t0_flag_set_a: assert property (@(posedge clk) disable iff (reset)
		t0_overflow_s |-> t0_flag_up_s)
		else $error("timer 0 flag not set on overflow");
	t1_flag_set_a: assert property (@(posedge clk) disable iff (reset)
		t1_ovf |=> t1_overflow_flag)
		else $error("timer 1 flag not set on overflow");
	stopped_hold_a: assert property (@(posedge clk) disable iff (reset)
		(!t0_run && !wr && (mode0 != tmr_pkg::MODE_SPLIT || !t1_run)) |=> $stable(t0_lo) && $stable(t0_hi))
		else $error("timer 0 moved while stopped");
	gate_block_a: assert property (@(posedge clk) disable iff (reset)
		(cfg0[tmr_pkg::BIT_GATE] && !xa_lvl) |-> !tick0)
		else $error("gated timer 0 counted with pin low");
	ungated_run_a: assert property (@(posedge clk) disable iff (reset)
		(!cfg0[tmr_pkg::BIT_GATE] && !cfg0[tmr_pkg::BIT_CNT_SEL] && t0_run && mc_tick) |-> tick0)
		else $error("ungated timer 0 failed to count");
	counter_edge_a: assert property (@(posedge clk) disable iff (reset)
		(cfg1[tmr_pkg::BIT_CNT_SEL] && tick1) |-> p1_fall)
		else $error("counter ticked without pin edge");
	split_stop_a: assert property (@(posedge clk) disable iff (reset)
		(mode1 == tmr_pkg::MODE_SPLIT) |-> !tick1)
		else $error("timer 1 ran in mode 3");
	level_track_a: assert property (@(posedge clk) disable iff (reset)
		(!ctrl_reg[tmr_pkg::BIT_X1_TYPE] && !wr_ctrl) |=> ext_ext_pin_b_detect == !$past(xb_lvl))
		else $error("level flag did not track pin");
	edge_latch_a: assert property (@(posedge clk) disable iff (reset)
		(ctrl_reg[tmr_pkg::BIT_X0_TYPE] && xa_fall && !wr_ctrl) |=> ext_ext_pin_a_detect)
		else $error("edge flag not latched");

	////////////////////////////////////////////////////////////////////////
	// register port
	rd_idle_zero_a: assert property (@(posedge clk) disable iff (reset)
		!rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	rd_ctrl_a: assert property (@(posedge clk) disable iff (reset)
		(rd && addr == tmr_pkg::ADDR_TCTRL) |=> rdata == $past(ctrl_reg))
		else $error("control read wrong");
	rd_tmode_a: assert property (@(posedge clk) disable iff (reset)
		(rd && addr == tmr_pkg::ADDR_TMODE) |=> rdata == $past(tmode_reg))
		else $error("mode read wrong");
	rd_t0lo_a: assert property (@(posedge clk) disable iff (reset)
		(rd && addr == tmr_pkg::ADDR_T0LO) |=> rdata == $past(t0_lo))
		else $error("timer 0 low read wrong");
	rd_t0hi_a: assert property (@(posedge clk) disable iff (reset)
		(rd && addr == tmr_pkg::ADDR_T0HI) |=> rdata == $past(t0_hi))
		else $error("timer 0 high read wrong");
	rd_t1lo_a: assert property (@(posedge clk) disable iff (reset)
		(rd && addr == tmr_pkg::ADDR_T1LO) |=> rdata == $past(t1_lo))
		else $error("timer 1 low read wrong");
	rd_t1hi_a: assert property (@(posedge clk) disable iff (reset)
		(rd && addr == tmr_pkg::ADDR_T1HI) |=> rdata == $past(t1_hi))
		else $error("timer 1 high read wrong");
	tmode_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_tmode |=> tmode_reg == $past(wdata))
		else $error("mode write lost");
	run0_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_ctrl |=> t0_run == $past(wdata[tmr_pkg::BIT_T0_RUN]))
		else $error("timer 0 run bit write lost");
	run1_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_ctrl |=> t1_run == $past(wdata[tmr_pkg::BIT_T1_RUN]))
		else $error("timer 1 run bit write lost");

	////////////////////////////////////////////////////////////////////////
	// flags: clears only act when no set lands in the same cycle
	sequence t1_flag_up_s;
		##1 t1_overflow_flag;
	endsequence

	t0_ack_clear_a: assert property (@(posedge clk) disable iff (reset)
		(ack[tmr_pkg::ACK_T0] && !set_t0 && !wr_ctrl) |=> !t0_overflow_flag)
		else $error("timer 0 flag not cleared on vectoring");
	t1_ack_clear_a: assert property (@(posedge clk) disable iff (reset)
		(ack[tmr_pkg::ACK_T1] && !set_t1 && !wr_ctrl) |=> !t1_overflow_flag)
		else $error("timer 1 flag not cleared on vectoring");
	t0_sw_set_a: assert property (@(posedge clk) disable iff (reset)
		(wr_ctrl && wdata[tmr_pkg::BIT_T0_FLAG]) |=> t0_overflow_flag)
		else $error("timer 0 flag software set lost");
	t1_sw_set_a: assert property (@(posedge clk) disable iff (reset)
		(wr_ctrl && wdata[tmr_pkg::BIT_T1_FLAG]) |-> t1_flag_up_s)
		else $error("timer 1 flag software set lost");
	x0_level_a: assert property (@(posedge clk) disable iff (reset)
		(!ctrl_reg[tmr_pkg::BIT_X0_TYPE] && !wr_ctrl) |=> ext_ext_pin_a_detect == !$past(xa_lvl))
		else $error("level flag 0 did not track pin");
	x0_hold_a: assert property (@(posedge clk) disable iff (reset)
		(ctrl_reg[tmr_pkg::BIT_X0_TYPE] && !wr_ctrl && !xa_fall && !ack[tmr_pkg::ACK_X0])
		|=> $stable(ext_ext_pin_a_detect))
		else $error("edge flag 0 changed without cause");
	x1_ack_clear_a: assert property (@(posedge clk) disable iff (reset)
		(ctrl_reg[tmr_pkg::BIT_X1_TYPE] && !wr_ctrl && ack[tmr_pkg::ACK_X1] && !x1_set)
		|=> !ext_ext_pin_b_detect)
		else $error("edge flag 1 not cleared on vectoring");
	x0_sw_set_a: assert property (@(posedge clk) disable iff (reset)
		(wr_ctrl && wdata[tmr_pkg::BIT_X0_TYPE] && wdata[tmr_pkg::BIT_X0_DET]) |=> ext_ext_pin_a_detect)
		else $error("edge flag 0 software set lost");
	x1_sw_set_a: assert property (@(posedge clk) disable iff (reset)
		(wr_ctrl && wdata[tmr_pkg::BIT_X1_TYPE] && wdata[tmr_pkg::BIT_X1_DET]) |=> ext_ext_pin_b_detect)
		else $error("edge flag 1 software set lost");
	split_flag_a: assert property (@(posedge clk) disable iff (reset)
		(mode0 == tmr_pkg::MODE_SPLIT && t0_hi_ovf) |-> t1_flag_up_s)
		else $error("split high half did not set timer 1 flag");

	////////////////////////////////////////////////////////////////////////
	// count sources and modes
	edge_keep_a: assert property (@(posedge clk) disable iff (reset)
		(edge_now[0] && !mc_tick) |=> edge_now[0])
		else $error("pending count edge lost before tick");
	div_range_a: assert property (@(posedge clk) disable iff (reset)
		div_reg <= 8'(CLKS_PER_CYCLE - 1))
		else $error("machine-cycle divider out of range");
	t0_wrap16_a: assert property (@(posedge clk) disable iff (reset)
		(tick0 && mode0 == tmr_pkg::MODE_16BIT && t0_hi == 8'hFF && t0_lo == 8'hFF) |-> t0_ovf)
		else $error("16-bit wrap gave no overflow");
	t1_reload_ovf_a: assert property (@(posedge clk) disable iff (reset)
		(tick1 && mode1 == tmr_pkg::MODE_RELOAD && t1_lo == 8'hFF) |-> t1_ovf)
		else $error("reload wrap gave no overflow");
	t1_c13_a: assert property (@(posedge clk) disable iff (reset)
		(tick1 && mode1 == tmr_pkg::MODE_13BIT) |-> t1_ovf == (t1_hi == 8'hFF && t1_lo[4:0] == 5'h1F))
		else $error("timer 1 13-bit carry wrong");
	t1_gate_a: assert property (@(posedge clk) disable iff (reset)
		(cfg1[tmr_pkg::BIT_GATE] && !xb_lvl) |-> !tick1)
		else $error("gated timer 1 counted with pin low");
	t0_stop_a: assert property (@(posedge clk) disable iff (reset)
		!t0_run |-> !tick0)
		else $error("timer 0 ticked while stopped");
	t1_stop_a: assert property (@(posedge clk) disable iff (reset)
		!t1_run |-> !tick1)
		else $error("timer 1 ticked while stopped");
	t0_count_edge_a: assert property (@(posedge clk) disable iff (reset)
		(cfg0[tmr_pkg::BIT_CNT_SEL] && tick0) |-> p0_fall)
		else $error("timer 0 counted without pin edge");
	t1_timer_tick_a: assert property (@(posedge clk) disable iff (reset)
		(!cfg1[tmr_pkg::BIT_CNT_SEL] && tick1) |-> mc_tick)
		else $error("timer 1 ticked off the machine cycle");
	t1_ungated_a: assert property (@(posedge clk) disable iff (reset)
		(!cfg1[tmr_pkg::BIT_GATE] && !cfg1[tmr_pkg::BIT_CNT_SEL] && t1_run && mc_tick
		&& mode1 != tmr_pkg::MODE_SPLIT) |-> tick1)
		else $error("ungated timer 1 failed to count");
endmodule

// ### include/tmr_pkg.sv
// constants for the dual timer/counter block
package tmr_pkg;
	// register indices on the plain register port
	localparam logic [3:0] ADDR_TCTRL = 4'h0;
	localparam logic [3:0] ADDR_TMODE = 4'h1;
	localparam logic [3:0] ADDR_T0LO  = 4'h2;
	localparam logic [3:0] ADDR_T0HI  = 4'h3;
	localparam logic [3:0] ADDR_T1LO  = 4'h4;
	localparam logic [3:0] ADDR_T1HI  = 4'h5;
	localparam logic [3:0] ADDR_ACK   = 4'h6;
	// timer_control_and_ext_int_flags fields
	localparam int BIT_T1_FLAG  = 7;
	localparam int BIT_T1_RUN   = 6;
	localparam int BIT_T0_FLAG  = 5;
	localparam int BIT_T0_RUN   = 4;
	localparam int BIT_X1_DET   = 3;
	localparam int BIT_X1_TYPE  = 2;
	localparam int BIT_X0_DET   = 1;
	localparam int BIT_X0_TYPE  = 0;
	// timer_mode_control fields: timer 1 in the upper nibble
	localparam int BIT_GATE     = 3;
	localparam int BIT_CNT_SEL  = 2;
	localparam int BIT_MODE_HI  = 1;
	localparam int BIT_MODE_LO  = 0;
	localparam int T1_NIBBLE    = 4;
	// acknowledge register bits (vectoring strobes)
	localparam int ACK_T0 = 0;
	localparam int ACK_T1 = 1;
	localparam int ACK_X0 = 2;
	localparam int ACK_X1 = 3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int PRESCALE_BITS = 5;
	typedef enum logic [1:0] {
		MODE_13BIT  = 2'b00,
		MODE_16BIT  = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT  = 2'b11
	} mode_e;
endpackage

// ### hdl/pin_sampler.sv
// synchroniser and falling-edge detector for one input pin
`timescale 1ns/1ns
module pin_sampler (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic pin,
	output logic      level,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// two flops before any use; third flop holds the last sample
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign fall  = prev_reg & ~sync_reg;
endmodule

// ### hdl/timer_core.sv
// one 16-bit timer/counter with four modes
`timescale 1ns/1ns
module timer_core (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [1:0] mode,
	input  wire logic       tick,
	input  wire logic       hi_tick,
	input  wire logic       wr_lo,
	input  wire logic       wr_hi,
	input  wire logic [7:0] wdata,
	output logic      [7:0] lo_byte,
	output logic      [7:0] hi_byte,
	output logic            ovf,
	output logic            hi_ovf
);
	logic [7:0] lo_reg;
	logic [7:0] hi_reg;
	logic [7:0] lo_next;
	logic [7:0] hi_next;
	logic [12:0] c13;
	logic [12:0] c13_inc;
	logic        c13_carry;
	logic [16:0] c16_inc;
	logic [8:0]  lo_inc;
	logic [8:0]  hi_inc;

	// mode 0: prescaler in the low five bits of the low byte
	assign c13 = {hi_reg, lo_reg[tmr_pkg::PRESCALE_BITS-1:0]};
	assign {c13_carry, c13_inc} = {1'b0, c13} + 14'h0001;
	assign c16_inc = {1'b0, hi_reg, lo_reg} + 17'h00001;
	assign lo_inc  = {1'b0, lo_reg} + 9'h001;
	assign hi_inc  = {1'b0, hi_reg} + 9'h001;

	always_comb begin
		lo_next = lo_reg;
		hi_next = hi_reg;
		ovf     = 1'b0;
		hi_ovf  = 1'b0;
		if (tick) begin
			case (mode)
				tmr_pkg::MODE_13BIT: begin
					lo_next = {lo_reg[7:tmr_pkg::PRESCALE_BITS], c13_inc[tmr_pkg::PRESCALE_BITS-1:0]};
					hi_next = c13_inc[12:tmr_pkg::PRESCALE_BITS];
					ovf     = c13_carry;
				end
				tmr_pkg::MODE_16BIT: begin
					{hi_next, lo_next} = c16_inc[15:0];
					ovf = c16_inc[16];
				end
				tmr_pkg::MODE_RELOAD: begin
					lo_next = lo_inc[8] ? hi_reg : lo_inc[7:0];
					ovf     = lo_inc[8];
				end
				default: begin
					lo_next = lo_inc[7:0];
					ovf     = lo_inc[8];
				end
			endcase
		end
		if (hi_tick && mode == tmr_pkg::MODE_SPLIT) begin
			hi_next = hi_inc[7:0];
			hi_ovf  = hi_inc[8];
		end
		if (wr_lo)
			lo_next = wdata;
		if (wr_hi)
			hi_next = wdata;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			lo_reg <= tmr_pkg::RESET_BYTE;
			hi_reg <= tmr_pkg::RESET_BYTE;
		end else begin
			lo_reg <= lo_next;
			hi_reg <= hi_next;
		end
	end

	assign lo_byte = lo_reg;
	assign hi_byte = hi_reg;

	reload_copy_a: assert property (@(posedge clk) disable iff (reset)
		(tick && mode == tmr_pkg::MODE_RELOAD && lo_reg == 8'hFF && !wr_lo && !wr_hi)
		|=> lo_reg == $past(hi_reg) && hi_reg == $past(hi_reg))
		else $error("reload did not copy high byte");
	c13_carry_a: assert property (@(posedge clk) disable iff (reset)
		(tick && mode == tmr_pkg::MODE_13BIT) |-> ovf == (hi_reg == 8'hFF && lo_reg[4:0] == 5'h1F))
		else $error("13-bit carry wrong");
endmodule

// ### bench/pin_model.sv
// stand-in for the count and interrupt pins that face the timer block
`timescale 1ns/1ns
module pin_model (
	input  wire logic clk,
	output logic      count_pin0,
	output logic      count_pin1,
	output logic      ext_pin_a,
	output logic      ext_pin_b
);
	logic [3:0] lvl = 4'hF;
	assign {ext_pin_b, ext_pin_a, count_pin1, count_pin0} = lvl;
	////////////////////////////////////////////////////////////////
	// each level held several clocks so one machine-cycle sample sees it
	task automatic pulse(input logic [3:0] m, input int n);
		repeat (n) begin
			@(posedge clk);
			lvl <= lvl & ~m;
			repeat (4) @(posedge clk);
			lvl <= lvl | m;
			repeat (3) @(posedge clk);
		end
	endtask
	// pins idle high; a low level is held until the bench lifts it
	task automatic hold(input logic [3:0] m, input logic v);
		@(posedge clk);
		lvl <= v ? (lvl | m) : (lvl & ~m);
	endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ns
module tb;
	logic       clk   = 1'b0;
	logic       reset = 1'b1;
	logic       wr    = 1'b0;
	logic       rd    = 1'b0;
	logic [3:0] addr  = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] w;
	logic       c0, c1, xa, xb;
	logic [3:0] outs;
	int         n_errors   = 0;
	int         n_compared = 0;
	always #20 clk = ~clk;
	// one machine cycle per clock keeps counts short
	dual_timer #(.CLKS_PER_CYCLE(1)) DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .count_pin0(c0), .count_pin1(c1), .ext_pin_a(xa), .ext_pin_b(xb),
		.t0_overflow_flag(outs[0]), .t1_overflow_flag(outs[1]), .ext_ext_pin_a_detect(outs[2]),
		.ext_ext_pin_b_detect(outs[3]));
	pin_model pins (.clk(clk), .count_pin0(c0), .count_pin1(c1), .ext_pin_a(xa), .ext_pin_b(xb));
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask
	task automatic setup(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] md);
		wr_reg(a, lo);
		wr_reg(a + 4'h1, hi);
		wr_reg(tmr_pkg::ADDR_TMODE, md);
	endtask
	task automatic wait_sig(input int s, input int n);
		int k;
		k = 0;
		while (outs[s] !== 1'b1) begin
			@(negedge clk);
			k++;
			if (k > n) begin
				n_errors++;
				close_out();
			end
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int a = 0; a < 8; a++)
			rd_chk(4'(a), 8'h00);
		// 13-bit mode from {FF,1E}: wraps in two ticks, upper low bits held
		setup(tmr_pkg::ADDR_T0LO, 8'hFE, 8'hFF, 8'h00);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h10);
		wait_sig(0, 12);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h00);
		rd_chk(tmr_pkg::ADDR_TCTRL, 8'h00);
		rd_chk(tmr_pkg::ADDR_T0HI, 8'h00);
		rd_reg(tmr_pkg::ADDR_T0LO, w);
		chk({5'h00, w[7:5]}, 8'h07);
		repeat (6) @(posedge clk);
		rd_chk(tmr_pkg::ADDR_T0LO, w);
		setup(tmr_pkg::ADDR_T0LO, 8'hF0, 8'hFF, 8'h01);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h10);
		wait_sig(0, 40);
		wr_reg(tmr_pkg::ADDR_ACK, 8'h01);
		rd_chk(tmr_pkg::ADDR_TCTRL, 8'h10);
		rd_chk(tmr_pkg::ADDR_T0HI, 8'h00);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h20);
		rd_chk(tmr_pkg::ADDR_TCTRL, 8'h20);
		// reload: the low byte must stay in the F0 band after wrapping
		setup(tmr_pkg::ADDR_T1LO, 8'hFE, 8'hF0, 8'h20);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h40);
		wait_sig(1, 12);
		wr_reg(tmr_pkg::ADDR_ACK, 8'h02);
		rd_chk(tmr_pkg::ADDR_TCTRL, 8'h40);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h00);
		rd_chk(tmr_pkg::ADDR_T1HI, 8'hF0);
		rd_reg(tmr_pkg::ADDR_T1LO, w);
		chk({4'h0, w[7:4]}, 8'h0F);
		pins.hold(4'h4, 1'b0);
		setup(tmr_pkg::ADDR_T0LO, 8'h00, 8'h00, 8'h09);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h10);
		repeat (8) @(posedge clk);
		rd_chk(tmr_pkg::ADDR_T0LO, 8'h00);
		wr_reg(tmr_pkg::ADDR_TMODE, 8'h01);
		repeat (8) @(posedge clk);
		rd_reg(tmr_pkg::ADDR_T0LO, w);
		chk({7'h00, w == 8'h00}, 8'h00);
		pins.hold(4'h4, 1'b1);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h00);
		setup(tmr_pkg::ADDR_T0LO, 8'h00, 8'h00, 8'h05);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h10);
		pins.pulse(4'h1, 5);
		repeat (4) @(posedge clk);
		rd_chk(tmr_pkg::ADDR_T0LO, 8'h05);
		// both inputs edge triggered, then input 1 in level mode
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h05);
		pins.pulse(4'hC, 1);
		rd_chk(tmr_pkg::ADDR_TCTRL, 8'h0F);
		chk({4'h0, outs}, 8'h0C);
		wr_reg(tmr_pkg::ADDR_ACK, 8'h0C);
		rd_chk(tmr_pkg::ADDR_TCTRL, 8'h05);
		chk({4'h0, outs}, 8'h00);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h00);
		pins.hold(4'h8, 1'b0);
		wait_sig(3, 8);
		pins.hold(4'h8, 1'b1);
		repeat (6) @(posedge clk);
		rd_chk(tmr_pkg::ADDR_TCTRL, 8'h00);
		// split mode: high half runs on timer 1 run bit, timer 1 halts
		setup(tmr_pkg::ADDR_T0LO, 8'h00, 8'hFE, 8'h33);
		wr_reg(tmr_pkg::ADDR_T1LO, 8'h00);
		wr_reg(tmr_pkg::ADDR_TCTRL, 8'h40);
		wait_sig(1, 12);
		rd_chk(tmr_pkg::ADDR_T0LO, 8'h00);
		rd_chk(tmr_pkg::ADDR_T1LO, 8'h00);
		close_out();
	end
endmodule
